// ---- design/sbmap_params.svh ----
// constants of the sideband subcarrier mapper: widths, vector indices, fifo sizing
// assumes inclusion by the mapper file, the checker and the bench, with sbmap_pkg.sv compiled alongside, one clock domain
`ifndef SBMAP_PARAMS_SVH
`define SBMAP_PARAMS_SVH
`define VEC_LEN 163
`define VEC_LAST 8'd162
`define VEC_CENTER 8'd81
`define SEC_BASE_IDX 8'd109
`define TER_BASE_IDX 8'd53
`define IDENT_NEG_IDX 8'd54
`define IDENT_POS_IDX 8'd108
`define REF_POS_IDX 8'd82
`define REF_NEG_IDX 8'd80
`define PT_W 4
`define SCALE_W 16
`define SAMPLE_W 21
`define WORD_W 6
`define COL_W 5
`define FIFO_W 14
`define FIFO_DEPTH 8
`define QAM_LARGE 4'sd3
`define QAM_SMALL 4'sd1
`endif

// ---- design/sbmap_pkg.sv ----
// types shared by the sideband subcarrier mapper
// assumes sbmap_params.svh is compiled alongside
package sbmap_pkg;
  typedef enum logic [2:0] {
    ST_MAP = 3'b001,
    ST_EMIT = 3'b010,
    ST_DRAIN = 3'b100
  } state_t;
  typedef enum logic [1:0] {
    KIND_SEC = 2'h0,
    KIND_TER = 2'h1,
    KIND_IDENT = 2'h2,
    KIND_REF = 2'h3
  } kind_t;
endpackage : sbmap_pkg

// ---- design/ofdm_sideband_subcarrier_mapper.sv ----
// sideband subcarrier mapper: fifo of matrix words in, one 163-entry vector out per symbol
// assumes words of one symbol arrive in any order, the last one flagged, one clock domain
// Behaviour
// - all-digital sec/ter use 64-QAM, ident 16-QAM
// - fetch word, map, scale I and Q, place
// - each column drives exactly one subcarrier, except the reference column, which fills +1 and -1
// - secondary columns 0..24 to subcarriers 28..52
// - tertiary negated conjugated onto -28..-52
// - ident column 0 at -27, column 1 at +27
// - ident at -27 negated conjugated, +27 plain
// - reference bit 0 gives -j0.5, 1 gives +j0.5
// - reference at +1, negated conjugate at -1
// - scale factor chosen per matrix and waveform
// - emit 163-entry complex vector per symbol
// - 16-QAM decoded from bit fields of word
// - power level selects between hybrid factor pairs
`include "sbmap_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sbmap_fifo #(
  parameter int WIDTH = `FIFO_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  // storage has no reset: nothing reads an entry before it is written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and occupancy; ready is registered so full is honest next cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule : sbmap_fifo

module ofdm_sideband_subcarrier_mapper (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // waveform and scale control
  input wire logic ALL_DIGITAL,
  input wire logic POWER_LEVEL_SELECT,
  input wire logic [`SCALE_W-1:0] ALLDIG_ENHANCED_SCALE,
  input wire logic [`SCALE_W-1:0] ALLDIG_IDENT_SCALE,
  input wire logic [`SCALE_W-1:0] ALLDIG_REFERENCE_SCALE,
  input wire logic [`SCALE_W-1:0] HYBRID_SECONDARY_SCALE_A,
  input wire logic [`SCALE_W-1:0] HYBRID_SECONDARY_SCALE_B,
  input wire logic [`SCALE_W-1:0] HYBRID_TERTIARY_SCALE_A,
  input wire logic [`SCALE_W-1:0] HYBRID_TERTIARY_SCALE_B,
  input wire logic [`SCALE_W-1:0] HYBRID_IDENT_SCALE_A,
  input wire logic [`SCALE_W-1:0] HYBRID_IDENT_SCALE_B,
  input wire logic [`SCALE_W-1:0] HYBRID_REFERENCE_SCALE,
  // 64-QAM table load
  input wire logic LUT_WE,
  input wire logic [`WORD_W-1:0] LUT_ADDR,
  input wire logic signed [`PT_W-1:0] LUT_I,
  input wire logic signed [`PT_W-1:0] LUT_Q,
  // interleaver words in
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [1:0] IN_KIND,
  input wire logic [`COL_W-1:0] IN_COL,
  input wire logic [`WORD_W-1:0] IN_WORD,
  input wire logic IN_LAST,
  // vector out to signal generator
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [7:0] OUT_IDX,
  output logic signed [`SAMPLE_W-1:0] OUT_I,
  output logic signed [`SAMPLE_W-1:0] OUT_Q,
  output logic OUT_LAST
);
  sbmap_pkg::state_t state_reg;
  logic signed [`PT_W-1:0] lut_i [64];
  logic signed [`PT_W-1:0] lut_q [64];
  logic signed [`SAMPLE_W-1:0] vec_i [`VEC_LEN];
  logic signed [`SAMPLE_W-1:0] vec_q [`VEC_LEN];
  logic [7:0] emit_idx_reg;
  logic f_valid;
  logic f_ready;
  logic [`FIFO_W-1:0] f_data;
  sbmap_pkg::kind_t f_kind;
  logic [`COL_W-1:0] f_col;
  logic [`WORD_W-1:0] f_word;
  logic f_last;
  logic take;
  logic emit_step;
  logic signed [`PT_W-1:0] pt_i;
  logic signed [`PT_W-1:0] pt_q;
  logic [`SCALE_W-1:0] scale;
  logic signed [`SAMPLE_W-1:0] sc_i;
  logic signed [`SAMPLE_W-1:0] sc_q;
  logic [7:0] pos_idx;
  logic [7:0] neg_idx;
  logic pos_we;
  logic neg_we;

  // words wait here while the vector is being emitted, stalling the interleaver
  sbmap_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .in_valid(IN_VALID),
    .in_ready(IN_READY),
    .in_data({IN_KIND, IN_COL, IN_WORD, IN_LAST}),
    .out_ready(f_ready),
    .out_valid(f_valid),
    .out_data(f_data)
  );

  assign f_kind = sbmap_pkg::kind_t'(f_data[13:12]);
  assign f_col = f_data[11:7];
  assign f_word = f_data[6:1];
  assign f_last = f_data[0];
  assign f_ready = (state_reg == sbmap_pkg::ST_MAP);
  assign take = f_valid && f_ready;
  assign emit_step = (!OUT_VALID || OUT_READY) && (state_reg == sbmap_pkg::ST_EMIT);

  // constellation point in half units, so 0.5 is 1 and 1.5 is 3
  always_comb begin
    pt_i = '0;
    pt_q = '0;
    unique case (f_kind)
      sbmap_pkg::KIND_SEC, sbmap_pkg::KIND_TER: begin
        pt_i = lut_i[f_word];
        pt_q = lut_q[f_word];
      end
      sbmap_pkg::KIND_IDENT: begin
        // bit 1 picks the I magnitude, bit 0 its sign (set means positive)
        pt_i = f_word[1] ? `QAM_SMALL : `QAM_LARGE;
        if (!f_word[0]) begin
          pt_i = -pt_i;
        end
        pt_q = f_word[3] ? `QAM_SMALL : `QAM_LARGE;
        if (!f_word[2]) begin
          pt_q = -pt_q;
        end
      end
      sbmap_pkg::KIND_REF: begin
        pt_i = '0;
        pt_q = f_word[0] ? `QAM_SMALL : -`QAM_SMALL;
      end
    endcase
  end

  // amplitude factor per matrix and waveform
  always_comb begin
    scale = '0;
    unique case (f_kind)
      sbmap_pkg::KIND_SEC: scale = ALL_DIGITAL ? ALLDIG_ENHANCED_SCALE :
        (POWER_LEVEL_SELECT ? HYBRID_SECONDARY_SCALE_B : HYBRID_SECONDARY_SCALE_A);
      sbmap_pkg::KIND_TER: scale = ALL_DIGITAL ? ALLDIG_ENHANCED_SCALE :
        (POWER_LEVEL_SELECT ? HYBRID_TERTIARY_SCALE_B : HYBRID_TERTIARY_SCALE_A);
      sbmap_pkg::KIND_IDENT: scale = ALL_DIGITAL ? ALLDIG_IDENT_SCALE :
        (POWER_LEVEL_SELECT ? HYBRID_IDENT_SCALE_B : HYBRID_IDENT_SCALE_A);
      sbmap_pkg::KIND_REF: scale = ALL_DIGITAL ? ALLDIG_REFERENCE_SCALE :
        HYBRID_REFERENCE_SCALE;
    endcase
  end

  // scale keeps a zero sign bit so the product stays signed and exact
  assign sc_i = `SAMPLE_W'(pt_i * $signed({1'b0, scale}));
  assign sc_q = `SAMPLE_W'(pt_q * $signed({1'b0, scale}));

  // slot selection; one slot per column, only the reference fills a mirrored pair
  always_comb begin
    pos_idx = '0;
    neg_idx = '0;
    pos_we = 1'b0;
    neg_we = 1'b0;
    unique case (f_kind)
      sbmap_pkg::KIND_SEC: begin
        pos_idx = `SEC_BASE_IDX + 8'(f_col);
        pos_we = take;
      end
      sbmap_pkg::KIND_TER: begin
        neg_idx = `TER_BASE_IDX - 8'(f_col);
        neg_we = take;
      end
      sbmap_pkg::KIND_IDENT: begin
        pos_idx = `IDENT_POS_IDX;
        neg_idx = `IDENT_NEG_IDX;
        pos_we = take && f_col[0];
        neg_we = take && !f_col[0];
      end
      sbmap_pkg::KIND_REF: begin
        pos_idx = `REF_POS_IDX;
        neg_idx = `REF_NEG_IDX;
        pos_we = take;
        neg_we = take;
      end
    endcase
  end

  // 64-QAM table, loadable at any time
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lut_i <= '{default: '0};
      lut_q <= '{default: '0};
    end else if (LUT_WE) begin
      lut_i[LUT_ADDR] <= LUT_I;
      lut_q[LUT_ADDR] <= LUT_Q;
    end
  end

  // symbol vector; an entry is cleared as it leaves, so the next symbol starts at zero
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vec_i <= '{default: '0};
      vec_q <= '{default: '0};
    end else begin
      if (pos_we) begin
        vec_i[pos_idx] <= sc_i;
        vec_q[pos_idx] <= sc_q;
      end
      if (neg_we) begin
        vec_i[neg_idx] <= -sc_i;
        vec_q[neg_idx] <= sc_q;
      end
      if (emit_step) begin
        vec_i[emit_idx_reg] <= '0;
        vec_q[emit_idx_reg] <= '0;
      end
    end
  end

  // sequencing: gather one symbol, then stream it out entry by entry
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= sbmap_pkg::ST_MAP;
      emit_idx_reg <= '0;
    end else begin
      unique case (state_reg)
        sbmap_pkg::ST_MAP: begin
          if (take && f_last) begin
            state_reg <= sbmap_pkg::ST_EMIT;
          end
          emit_idx_reg <= '0;
        end
        sbmap_pkg::ST_EMIT: begin
          if (emit_step) begin
            emit_idx_reg <= emit_idx_reg + 8'h01;
            if (emit_idx_reg == `VEC_LAST) begin
              state_reg <= sbmap_pkg::ST_DRAIN;
            end
          end
        end
        sbmap_pkg::ST_DRAIN: begin
          if (OUT_READY) begin
            state_reg <= sbmap_pkg::ST_MAP;
          end
        end
      endcase
    end
  end

  // output register toward the signal generator
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OUT_VALID <= 1'b0;
      OUT_IDX <= '0;
      OUT_I <= '0;
      OUT_Q <= '0;
      OUT_LAST <= 1'b0;
    end else if (emit_step) begin
      OUT_VALID <= 1'b1;
      OUT_IDX <= emit_idx_reg;
      OUT_I <= vec_i[emit_idx_reg];
      OUT_Q <= vec_q[emit_idx_reg];
      OUT_LAST <= (emit_idx_reg == `VEC_LAST);
    end else if (OUT_READY) begin
      OUT_VALID <= 1'b0;
      OUT_LAST <= 1'b0;
    end
  end
endmodule : ofdm_sideband_subcarrier_mapper

`default_nettype wire

// ---- tb/sbmap_asserts.sv ----
// stream checker of the sideband mapper, sees only top ports
// assumes binding to the mapper top, one clock domain
`include "sbmap_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sbmap_asserts (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // word and vector streams
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic IN_LAST,
  input wire logic OUT_VALID,
  input wire logic OUT_READY,
  input wire logic [7:0] OUT_IDX,
  input wire logic signed [`SAMPLE_W-1:0] OUT_I,
  input wire logic signed [`SAMPLE_W-1:0] OUT_Q,
  input wire logic OUT_LAST
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // the last flag marks only the top index
  property p_last; OUT_VALID && OUT_LAST |-> OUT_IDX == `VEC_LAST; endproperty
  a_last: assert property (p_last) else $error("last flag off top index");
  // accepted entries advance by one with no gap
  property p_step; OUT_VALID && OUT_READY && !OUT_LAST
    |=> OUT_VALID && OUT_IDX == $past(OUT_IDX) + 8'd1; endproperty
  a_step: assert property (p_step) else $error("index did not advance");
  // a stalled entry must not move
  property p_hold; OUT_VALID && !OUT_READY
    |=> OUT_VALID && $stable(OUT_IDX) && $stable(OUT_I) && $stable(OUT_Q); endproperty
  a_hold: assert property (p_hold) else $error("stalled entry changed");
  // each vector opens at index zero
  property p_first; $rose(OUT_VALID) |-> OUT_IDX == 8'h00; endproperty
  a_first: assert property (p_first) else $error("vector not opened at zero");
  // stream pauses after the last entry
  property p_end; OUT_VALID && OUT_READY && OUT_LAST |=> !OUT_VALID; endproperty
  a_end: assert property (p_end) else $error("valid held past last entry");
  property p_range; OUT_VALID |-> OUT_IDX <= `VEC_LAST; endproperty
  a_range: assert property (p_range) else $error("index out of vector");
  // slots no column of this block reaches stay zero
  property p_zero; OUT_VALID && (OUT_IDX inside {[8'h00:8'h1c], [8'h37:8'h4f], 8'h51,
    [8'h53:8'h6b], [8'h86:8'ha2]}) |-> OUT_I == 0 && OUT_Q == 0; endproperty
  a_zero: assert property (p_zero) else $error("undriven slot not zero");
  // a closed symbol starts emission soon; fifo holds at most eight words
  property p_start; IN_VALID && IN_READY && IN_LAST && !OUT_VALID
    |-> ##[1:12] OUT_VALID; endproperty
  a_start: assert property (p_start) else $error("emission did not start");
endmodule : sbmap_asserts
bind ofdm_sideband_subcarrier_mapper sbmap_asserts sbmap_asserts_i (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
  .IN_LAST(IN_LAST), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_IDX(OUT_IDX),
  .OUT_I(OUT_I), .OUT_Q(OUT_Q), .OUT_LAST(OUT_LAST));
`default_nettype wire

// ---- tb/sbmap_sink.sv ----
// vector sink standing in for the signal generator
// assumes one clock; slow makes it stall every other cycle
`timescale 1ns/1ps
`default_nettype none
module sbmap_sink (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bench control
  input wire logic slow,
  // vector stream
  input wire logic out_valid,
  input wire logic [7:0] out_idx,
  input wire logic signed [20:0] out_i,
  input wire logic signed [20:0] out_q,
  input wire logic out_last,
  output logic out_ready
);
  logic signed [20:0] vi [163];
  logic signed [20:0] vq [163];
  int frames;
  logic tog_reg;
  // stall toggles every rising edge so held entries are really exercised
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tog_reg <= 1'b0;
    else tog_reg <= ~tog_reg;
  end
  // keep accepted entries, count vectors closed by the last flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) frames <= 0;
    else if (out_valid && out_ready) begin
      vi[out_idx] <= out_i;
      vq[out_idx] <= out_q;
      if (out_last) frames <= frames + 1;
    end
  end
  assign out_ready = slow ? tog_reg : 1'b1;
endmodule : sbmap_sink
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the sideband subcarrier mapper
// assumes the sink model and the bound checker are compiled alongside
`include "sbmap_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  logic clk = 0, rst_n = 0, ad = 1, pl = 0, we = 0, iv = 0, il = 0, slow = 0;
  logic [15:0] se = 16'h0003, si = 16'h0005, sr = 16'h0007, sa = 16'h0002, sb = 16'h0006;
  logic [15:0] ta = 16'h0009, tb = 16'h000b, ia = 16'h0004, ib = 16'h000a, hr = 16'h000c;
  logic [5:0] la = 0, iw = 0;
  logic signed [3:0] li = 0, lq = 0;
  logic [1:0] ik = 0;
  logic [4:0] ic = 0;
  logic ov, ordy, ir, ol;
  logic [7:0] ox;
  logic signed [20:0] oi, oq;
  logic signed [20:0] ei [163] = '{default: 0};
  logic signed [20:0] eq [163] = '{default: 0};
  int error_cnt = 0, cmp_count = 0, nf = 0;
  always #4 clk = ~clk;
  ofdm_sideband_subcarrier_mapper ofdm_sideband_subcarrier_mapper_i (.CORE_CLK(clk),
    .ARST_N(rst_n), .ALL_DIGITAL(ad), .POWER_LEVEL_SELECT(pl), .ALLDIG_ENHANCED_SCALE(se),
    .ALLDIG_IDENT_SCALE(si), .ALLDIG_REFERENCE_SCALE(sr), .HYBRID_SECONDARY_SCALE_A(sa),
    .HYBRID_SECONDARY_SCALE_B(sb), .HYBRID_TERTIARY_SCALE_A(ta), .HYBRID_TERTIARY_SCALE_B(tb),
    .HYBRID_IDENT_SCALE_A(ia), .HYBRID_IDENT_SCALE_B(ib), .HYBRID_REFERENCE_SCALE(hr),
    .LUT_WE(we), .LUT_ADDR(la), .LUT_I(li), .LUT_Q(lq), .IN_VALID(iv), .IN_READY(ir),
    .IN_KIND(ik), .IN_COL(ic), .IN_WORD(iw), .IN_LAST(il), .OUT_VALID(ov), .OUT_READY(ordy),
    .OUT_IDX(ox), .OUT_I(oi), .OUT_Q(oq), .OUT_LAST(ol));
  sbmap_sink sbmap_sink_i (.clk(clk), .arst_n(rst_n), .slow(slow), .out_valid(ov),
    .out_idx(ox), .out_i(oi), .out_q(oq), .out_last(ol), .out_ready(ordy));
  task automatic lut(input logic [5:0] a, input logic signed [3:0] i, q);
    @(negedge clk);
    we = 1;
    la = a;
    li = i;
    lq = q;
    @(negedge clk);
    we = 0;
  endtask : lut
  // offer one word, held until the fifo takes it
  task automatic put(input logic [1:0] k, input logic [4:0] c, input logic [5:0] w, input logic l);
    @(negedge clk);
    iv = 1;
    ik = k;
    ic = c;
    iw = w;
    il = l;
    while (ir !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask : put
  // expected point; mirrored slots negate I only
  task automatic place(input int x, pi, pq, s, input bit m);
    ei[x] = (m ? -pi : pi) * s;
    eq[x] = pq * s;
  endtask : place
  task automatic refb(input bit b, input int s);
    put(2'h3, 5'h00, {5'h00, b}, 1'b1);
    place(82, 0, b ? 1 : -1, s, 0);
    place(80, 0, b ? 1 : -1, s, 1);
  endtask : refb
  function automatic int qi(input logic [3:0] w);
    return (w[1] ? 1 : 3) * (w[0] ? 1 : -1);
  endfunction : qi
  function automatic int qq(input logic [3:0] w);
    return (w[3] ? 1 : 3) * (w[2] ? 1 : -1);
  endfunction : qq
  // wait for the next vector and compare all entries, then clear expectations
  task automatic frame();
    int t = 0;
    @(negedge clk);
    iv = 0;
    nf++;
    while (sbmap_sink_i.frames < nf && t < 4000) begin
      @(negedge clk);
      t++;
    end
    // a vector that never closes counts against the run
    if (t >= 4000) error_cnt++;
    for (int x = 0; x < `VEC_LEN; x++) begin
      `CHK(sbmap_sink_i.vi[x], ei[x])
      `CHK(sbmap_sink_i.vq[x], eq[x])
      ei[x] = 0;
      eq[x] = 0;
    end
  endtask : frame
  task automatic t_alldig();
    slow = 1;
    lut(6'h05, 4'sd3, -4'sd5);
    lut(6'h2a, -4'sd7, 4'sd1);
    put(2'h0, 5'd0, 6'h05, 0);
    place(109, 3, -5, se, 0);
    put(2'h0, 5'd24, 6'h2a, 0);
    place(133, -7, 1, se, 0);
    put(2'h1, 5'd0, 6'h05, 0);
    place(53, 3, -5, se, 1);
    put(2'h1, 5'd24, 6'h2a, 0);
    place(29, -7, 1, se, 1);
    put(2'h2, 5'd0, 6'h00, 0);
    place(54, -3, -3, si, 1);
    put(2'h2, 5'd1, 6'h0f, 0);
    place(108, 1, 1, si, 0);
    refb(1, sr);
    frame();
    $display("test alldig done");
  endtask : t_alldig
  task automatic t_hybrid();
    slow = 0;
    ad = 0;
    for (int p = 0; p < 2; p++) begin
      pl = p[0];
      put(2'h0, 5'd3, 6'h05, 0);
      place(112, 3, -5, p ? sb : sa, 0);
      put(2'h1, 5'd3, 6'h2a, 0);
      place(50, -7, 1, p ? tb : ta, 1);
      put(2'h2, 5'd1, 6'h09, 0);
      place(108, 3, -1, p ? ib : ia, 0);
      refb(0, hr);
      frame();
    end
    ad = 1;
    $display("test hybrid done");
  endtask : t_hybrid
  task automatic t_qam16();
    for (int w = 0; w < 16; w += 2) begin
      put(2'h2, 5'd0, w[5:0], 0);
      place(54, qi(w[3:0]), qq(w[3:0]), si, 1);
      put(2'h2, 5'd1, w[5:0] + 6'h01, 0);
      place(108, qi(w[3:0] + 4'h1), qq(w[3:0] + 4'h1), si, 0);
      refb(w[1], sr);
      frame();
    end
    $display("test qam16 done");
  endtask : t_qam16
  // fifo is not drained while a vector streams out, so it refuses the ninth word
  task automatic t_fill();
    slow = 1;
    put(2'h3, 5'd0, 6'h01, 1);
    // drop valid at once, or the fifo keeps taking copies of the closing word
    @(negedge clk);
    iv = 0;
    nf++;
    while (ov !== 1'b1) @(negedge clk);
    for (int n = 0; n < 8; n++) begin
      put(2'h0, 5'd10 + n[4:0], 6'h05, n == 7);
      place(119 + n, 3, -5, se, 0);
    end
    @(negedge clk);
    `CHK(ir, 1'b0)
    frame();
    $display("test fill done");
  endtask : t_fill
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    `CHK(ov, 1'b0)
    `CHK(ir, 1'b1)
    t_alldig();
    t_hybrid();
    t_qam16();
    t_fill();
    summarize();
  end
  // watchdog: the whole run needs about three thousand cycles
  initial begin
    #80000;
    error_cnt++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
